// ===== msd_pkg.sv
package msd_pkg;

  // Internal RAM
  localparam int          IRAM_BYTES     = 256;
  localparam logic [7:0]  IRAM_UPPER_BIT = 8'h80;
  localparam int          RAM_AW         = 8;
  localparam int          IRAM_LOW_BYTES = 128;
  localparam logic [2:0]  WREG_IND_MAX   = 3'h1;

  // External data space
  localparam logic [15:0] EXTERNAL_DATA_RAM_LO        = 16'h0000;
  localparam logic [15:0] EXTERNAL_DATA_RAM_HI        = 16'h01FF;
  localparam logic [15:0] LED_LO         = 16'h0200;
  localparam logic [15:0] LED_HI         = 16'h020F;
  localparam int          EXTERNAL_DATA_RAM_BYTES     = 512;
  localparam int          LED_BYTES      = 16;
  localparam logic [7:0]  PAGE_SFR_ADDR  = 8'hA0;
  localparam logic [7:0]  PAGE_RESET     = 8'hFF;

  // Flash regions
  localparam logic [15:0] CODE_LO        = 16'h0000;
  localparam logic [15:0] CODE_HI        = 16'h3BFF;
  localparam logic [15:0] DFL_LO         = 16'h3C00;
  localparam logic [15:0] DFL_HI         = 16'h3FFF;
  localparam logic [15:0] DFA_LO         = 16'h4400;
  localparam logic [15:0] DFA_HI         = 16'h45FF;
  localparam logic [15:0] DFB_LO         = 16'h4600;
  localparam logic [15:0] DFB_HI         = 16'h47FF;
  localparam logic [15:0] INFO_LO        = 16'h4200;
  localparam logic [15:0] INFO_HI        = 16'h43FF;
  localparam logic [15:0] SYS_LO         = 16'h8000;
  localparam logic [15:0] SYS_HI         = 16'h81FF;
  localparam logic [15:0] UID_LO         = 16'h43A8;
  localparam logic [15:0] UID_HI         = 16'h43AF;

  // Internal access mode
  typedef enum logic [1:0] {
    AM_DIRECT   = 2'h0,
    AM_INDIRECT = 2'h1
  } addr_mode_e;

  // Flash operations
  typedef enum logic [1:0] {
    FOP_NONE  = 2'h0,
    FOP_BLOCK = 2'h1,
    FOP_PAGE  = 2'h2,
    FOP_WRITE = 2'h3
  } flash_op_e;

  // Internal data request
  typedef struct packed {
    logic       vld;
    logic       wr;
    addr_mode_e mode;
    logic [2:0] wreg;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iacc_s;

  // External data request
  typedef struct packed {
    logic       vld;
    logic       wr;
    logic       via_wreg;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xacc_s;

  // Flash region select, one bit per region; id bytes also set the info bit
  typedef struct packed {
    logic code;
    logic data_main;
    logic data_a;
    logic data_b;
    logic info;
    logic sys;
    logic unique_id_bytes;
  } fsel_s;

endpackage

// ===== flash_region_decode.sv
`timescale 1ns/10ps
module flash_region_decode
  import msd_pkg::*;
(
  input  wire logic [15:0]         addr, // Flash byte address
  output msd_pkg::fsel_s           sel   // Region selects
);
  import msd_pkg::*;

  // Inclusive range test, used for every region
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  assign sel.code      = in_rng(addr, CODE_LO, CODE_HI);
  assign sel.data_main = in_rng(addr, DFL_LO, DFL_HI);
  assign sel.data_a    = in_rng(addr, DFA_LO, DFA_HI);
  assign sel.data_b    = in_rng(addr, DFB_LO, DFB_HI);
  assign sel.info      = in_rng(addr, INFO_LO, INFO_HI);
  assign sel.sys       = in_rng(addr, SYS_LO, SYS_HI);
  // Id bytes live inside the information page
  assign sel.unique_id_bytes       = in_rng(addr, UID_LO, UID_HI);
endmodule

// ===== memory_space_decoder.sv
`timescale 1ns/10ps
// Contract
// - 256 bytes internal RAM, 00H to FFH
// - Low half same for direct and indirect
// - Upper RAM only via indirect working register
// - Direct 80H-FFH goes to SFR space
// - 512 external RAM bytes 0000H-01FFH
// - 200H-20FH is LED display cache
// - Code flash 0000H-3BFFH, 30 pages
// - Data flash 1K page 3C00H-3FFFH
// - Two 512 byte data pages above 4400H
// - Information page 4200H-43FFH
// - System page 8000H-81FFH
// - Code flash: block, page erase, byte write
// - Data flash: page erase, byte write only
// - Register index 0-7, indirect only 0-1
// - Indirect external high byte from page register
module memory_space_decoder
  import msd_pkg::*;
#(
  parameter int XBYTES   = EXTERNAL_DATA_RAM_BYTES, // External RAM depth
  parameter int LEDBYTES = LED_BYTES   // Display cache depth
) (
  input  wire logic                clk,        // 125 MHz system clock
  input  wire logic                rstn,       // Async reset, active low
  input  msd_pkg::iacc_s           iacc,       // Internal data request
  input  msd_pkg::xacc_s           xacc,       // External data request
  input  wire logic [7:0]          sfr_rdata,  // Read data from SFR block
  input  wire logic [15:0]         faddr,      // Flash address from core
  input  msd_pkg::flash_op_e       fop,        // Flash operation request
  input  wire logic                icp_mode,   // In-circuit programming path active
  output logic [7:0]               irdata,     // Internal read data
  output logic                     irvalid,    // Internal read data valid
  output logic                     sfr_sel,    // SFR access strobe
  output logic                     sfr_wr,     // SFR write strobe
  output logic [7:0]               sfr_addr,   // SFR address
  output logic [7:0]               sfr_wdata,  // SFR write data
  output logic                     ierr,       // Bad working register index
  output logic [7:0]               xrdata,     // External read data
  output logic                     xrvalid,    // External read data valid
  output logic [LEDBYTES*8-1:0]    led_cache,  // Display cache to LED driver
  output msd_pkg::fsel_s           fsel,       // Registered flash region select
  output logic                     fop_ok,     // Flash operation accepted pulse
  output logic                     fop_rej     // Flash operation refused pulse
);
  import msd_pkg::*;

  // Storage arrays
  logic [7:0] iram_q [IRAM_BYTES];      // Whole internal RAM, both halves
  logic [7:0] external_data_ram_q [XBYTES];          // External data RAM
  logic [7:0] led_q  [LEDBYTES];        // Display cache
  logic [7:0] page_q;                   // High byte for indirect external access

  // Internal decode
  wire        lo_half  = (iacc.addr & IRAM_UPPER_BIT) == 8'h00;
  wire        ind      = (iacc.mode == AM_INDIRECT);
  // Indirect uses only registers 0 and 1; anything else is refused
  wire        ind_bad  = ind && (iacc.wreg > WREG_IND_MAX);
  wire        iram_hit = iacc.vld && !ind_bad && (lo_half || ind);
  wire        sfr_hit  = iacc.vld && !ind && !lo_half;
  wire        page_hit = sfr_hit && (iacc.addr == PAGE_SFR_ADDR);

  // Inclusive range test shared by the external decode
  function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  // External decode
  wire [15:0] xaddr    = xacc.via_wreg ? {page_q, xacc.addr[7:0]} : xacc.addr;
  wire        external_data_ram_hit = xacc.vld && in_span(xaddr, EXTERNAL_DATA_RAM_LO, EXTERNAL_DATA_RAM_HI);
  wire        led_hit  = xacc.vld && in_span(xaddr, LED_LO, LED_HI);
  wire [3:0]  led_idx  = xaddr[3:0];
  wire [8:0]  external_data_ram_idx = xaddr[8:0];

  // Flash region and operation legality
  fsel_s      fsel_d;
  flash_region_decode u_frd (
    .addr (faddr),
    .sel  (fsel_d)
  );
  wire        is_code  = fsel_d.code;
  wire        is_data  = fsel_d.data_main | fsel_d.data_a | fsel_d.data_b;
  // Block erase only for code; data pages take page erase and byte write
  wire        op_legal = icp_mode && ((is_code && fop != FOP_NONE) ||
                         (is_data && (fop == FOP_PAGE || fop == FOP_WRITE)));

  // Internal RAM write; one array serves both halves, mode picks reachability
  always_ff @(posedge clk) begin
    if (iram_hit && iacc.wr) begin
      iram_q[iacc.addr] <= iacc.wdata;
    end
  end

  // External RAM writes; other addresses dropped
  always_ff @(posedge clk) begin
    if (external_data_ram_hit && xacc.wr) begin
      external_data_ram_q[external_data_ram_idx] <= xacc.wdata;
    end
  end

  // Display cache resets to blank so the driver starts dark
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < LEDBYTES; i++) led_q[i] <= 8'h00;
    end else if (led_hit && xacc.wr) begin
      led_q[led_idx] <= xacc.wdata;
    end
  end

  // Page register, kept here since only this block consumes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      page_q <= PAGE_RESET;
    end else if (page_hit && iacc.wr) begin
      page_q <= iacc.wdata;
    end
  end

  // Internal read path, one cycle latency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irdata  <= 8'h00;
      irvalid <= 1'b0;
    end else begin
      irvalid <= iacc.vld && !iacc.wr && !ind_bad;
      if (iram_hit) begin
        irdata <= iram_q[iacc.addr];
      end else if (page_hit) begin
        irdata <= page_q;
      end else if (sfr_hit) begin
        irdata <= sfr_rdata;
      end else begin
        irdata <= 8'h00;
      end
    end
  end

  // SFR strobes registered; page register is not forwarded
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_sel   <= 1'b0;
      sfr_wr    <= 1'b0;
      sfr_addr  <= 8'h00;
      sfr_wdata <= 8'h00;
      ierr      <= 1'b0;
    end else begin
      sfr_sel   <= sfr_hit && !page_hit;
      sfr_wr    <= sfr_hit && !page_hit && iacc.wr;
      sfr_addr  <= iacc.addr;
      sfr_wdata <= iacc.wdata;
      ierr      <= iacc.vld && ind_bad;
    end
  end

  // External read path; unmapped reads return zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xrdata  <= 8'h00;
      xrvalid <= 1'b0;
    end else begin
      xrvalid <= xacc.vld && !xacc.wr;
      if (external_data_ram_hit) begin
        xrdata <= external_data_ram_q[external_data_ram_idx];
      end else if (led_hit) begin
        xrdata <= led_q[led_idx];
      end else begin
        xrdata <= 8'h00;
      end
    end
  end

  // Flatten cache for the driver
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_cache <= '0;
    end else begin
      for (int i = 0; i < LEDBYTES; i++) led_cache[i*8 +: 8] <= led_q[i];
    end
  end

  // Flash select and operation verdict, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fsel    <= '0;
      fop_ok  <= 1'b0;
      fop_rej <= 1'b0;
    end else begin
      fsel    <= fsel_d;
      fop_ok  <= (fop != FOP_NONE) && op_legal;
      fop_rej <= (fop != FOP_NONE) && !op_legal;
    end
  end

  // Checks; answers are looked at one edge after the request, the cache write two edges after
  // Direct upper access leaves as an SFR strobe, except the local page register
  upper_direct_a: assert property (@(posedge clk) disable iff (!rstn)
    (iacc.vld && iacc.mode == AM_DIRECT && iacc.addr >= IRAM_UPPER_BIT && iacc.addr != PAGE_SFR_ADDR)
      |=> sfr_sel) else $error("direct upper access missed SFR");
  // Low half answers from RAM in either mode
  low_half_a: assert property (@(posedge clk) disable iff (!rstn)
    (iacc.vld && !iacc.wr && iacc.addr < IRAM_UPPER_BIT && !ind_bad) |=> !sfr_sel && irvalid)
    else $error("low half access misrouted");
  // Indirect never leaks onto the SFR side
  ind_upper_a: assert property (@(posedge clk) disable iff (!rstn)
    (iacc.vld && ind && !ind_bad) |=> !sfr_sel) else $error("indirect reached SFR");
  ind_reg_a: assert property (@(posedge clk) disable iff (!rstn)
    (iacc.vld && ind && iacc.wreg > WREG_IND_MAX) |=> ierr && !irvalid) else $error("bad index accepted");
  // A legal index must never raise the error pulse
  good_reg_a: assert property (@(posedge clk) disable iff (!rstn)
    (iacc.vld && !ind_bad) |=> !ierr) else $error("good index flagged");
  page_rst_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> page_q == PAGE_RESET) else $error("page reset wrong");
  // Every external read is answered, mapped or not
  ext_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (xacc.vld && !xacc.wr) |=> xrvalid) else $error("external read unanswered");
  xunmap_a: assert property (@(posedge clk) disable iff (!rstn)
    (xacc.vld && !xacc.wr && xaddr > LED_HI) |=> xrdata == 8'h00) else $error("unmapped read nonzero");
  // Cache write shows on the driver side two edges later
  led_wr_a: assert property (@(posedge clk) disable iff (!rstn)
    (led_hit && xacc.wr) |=> ##1 led_cache[$past(led_idx,2)*8 +: 8] == $past(xacc.wdata,2))
    else $error("cache write lost");
  data_block_a: assert property (@(posedge clk) disable iff (!rstn)
    (fop == FOP_BLOCK && !is_code) |=> !fop_ok && fop_rej) else $error("block erase on non-code");
  code_ops_a: assert property (@(posedge clk) disable iff (!rstn)
    (icp_mode && fop != FOP_NONE && is_code) |=> fop_ok) else $error("code op refused");
  region_a: assert property (@(posedge clk) disable iff (!rstn)
    (faddr == DFL_LO) |=> fsel.data_main && !fsel.code) else $error("data page misdecoded");
endmodule

// ===== core_model.sv
`timescale 1ns/10ps
module core_model
  import msd_pkg::*;
(
  input  wire logic          clk,       // System clock
  output msd_pkg::iacc_s     iacc,      // Internal data request
  output msd_pkg::xacc_s     xacc,      // External data request
  output logic [7:0]         sfr_rdata, // Stand-in SFR read data
  output logic [15:0]        faddr,     // Flash address
  output msd_pkg::flash_op_e fop,       // Flash operation request
  output logic               icp_mode   // Programming path level
);
  // SFR data tracks the address, so a stale or wrong capture shows up
  assign sfr_rdata = iacc.addr ^ 8'h5A;

  // Idle bus from time zero
  initial begin
    iacc = '0;
    xacc = '0;
    faddr = 16'h0000;
    fop = FOP_NONE;
    icp_mode = 1'b0;
  end

  // One internal request; returns just after the answer edge
  task automatic ireq(input logic w, input addr_mode_e m, input logic [2:0] r, input logic [7:0] a, d);
    @(posedge clk);
    iacc <= '{1'b1, w, m, r, a, d};
    @(posedge clk);
    iacc <= '0;
    #1;
  endtask

  // One external request; the high address byte is ignored when indirect
  task automatic xreq(input logic w, input logic ind, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    xacc <= '{1'b1, w, ind, a, d};
    @(posedge clk);
    xacc <= '0;
    #1;
  endtask

  // Flash address and operation held for one sampling edge
  task automatic freq(input logic [15:0] a, input flash_op_e op, input logic in_circuit_programming);
    @(posedge clk);
    faddr <= a;
    fop <= op;
    icp_mode <= in_circuit_programming;
    @(posedge clk);
    fop <= FOP_NONE;
    #1;
  endtask

  // Id bytes are read in ascending order with no operation attached
  task automatic uid_read(input int i);
    freq(UID_LO + 16'(i), FOP_NONE, 1'b0);
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
  import msd_pkg::*;
  logic         clk, rstn;                                   // Clock and reset
  iacc_s        iacc;                                        // Internal request
  xacc_s        xacc;                                        // External request
  logic [7:0]   sfr_rdata, irdata, xrdata, sfr_addr, sfr_wdata; // Data buses
  logic [15:0]  faddr;                                       // Flash address
  flash_op_e    fop;                                         // Flash operation
  logic         icp_mode, irvalid, sfr_sel, sfr_wr, ierr;    // Strobes
  logic         xrvalid, fop_ok, fop_rej;                    // Strobes
  logic [127:0] led_cache;                                   // Display cache
  fsel_s        fsel;                                        // Region select
  int           error_cnt, checked;                          // Tallies

  memory_space_decoder u_memory_space_decoder (.clk(clk), .rstn(rstn), .iacc(iacc), .xacc(xacc),
    .sfr_rdata(sfr_rdata), .faddr(faddr), .fop(fop), .icp_mode(icp_mode), .irdata(irdata),
    .irvalid(irvalid), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .ierr(ierr), .xrdata(xrdata), .xrvalid(xrvalid), .led_cache(led_cache), .fsel(fsel),
    .fop_ok(fop_ok), .fop_rej(fop_rej));
  core_model u_core_model (.clk(clk), .iacc(iacc), .xacc(xacc), .sfr_rdata(sfr_rdata),
    .faddr(faddr), .fop(fop), .icp_mode(icp_mode));

  // Free-running clock at 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Shared mismatch reporting
  task automatic note(input logic ok, input logic [127:0] got, exp);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, exp);
    note(got === exp, 128'(got), 128'(exp));
  endtask
  task automatic cmp_byte(input logic [7:0] got, exp);
    note(got === exp, 128'(got), 128'(exp));
  endtask
  task automatic cmp_sel(input fsel_s got, input logic [6:0] exp);
    note(got === exp, 128'(got), 128'(exp));
  endtask

  // Internal RAM: low half shared, upper half indirect only, direct upper to SFR
  task automatic t_iram;
    u_core_model.ireq(1'b1, AM_DIRECT, 3'h0, 8'h10, 8'hA5);
    u_core_model.ireq(1'b0, AM_INDIRECT, 3'h1, 8'h10, 8'h00);
    cmp_byte(irdata, 8'hA5);
    cmp_bit(irvalid, 1'b1);
    cmp_bit(ierr, 1'b0);
    u_core_model.ireq(1'b1, AM_INDIRECT, 3'h0, 8'hFF, 8'hC3);
    u_core_model.ireq(1'b1, AM_DIRECT, 3'h0, 8'hFF, 8'h77);
    cmp_bit(sfr_wr, 1'b1);
    cmp_byte(sfr_wdata, 8'h77);
    u_core_model.ireq(1'b0, AM_INDIRECT, 3'h0, 8'hFF, 8'h00);
    cmp_byte(irdata, 8'hC3);
    cmp_bit(sfr_sel, 1'b0);
    u_core_model.ireq(1'b0, AM_DIRECT, 3'h0, 8'h85, 8'h00);
    cmp_bit(sfr_sel, 1'b1);
    cmp_byte(sfr_addr, 8'h85);
    cmp_byte(irdata, 8'hDF);
  endtask

  // Indirect through a register above 1 is refused and leaves RAM alone
  task automatic t_refuse;
    u_core_model.ireq(1'b1, AM_DIRECT, 3'h0, 8'h20, 8'h11);
    u_core_model.ireq(1'b1, AM_INDIRECT, 3'h7, 8'h20, 8'h99);
    cmp_bit(ierr, 1'b1);
    cmp_bit(irvalid, 1'b0);
    u_core_model.ireq(1'b0, AM_DIRECT, 3'h2, 8'h20, 8'h00);
    cmp_byte(irdata, 8'h11);
  endtask

  // External RAM, page register, display cache and unmapped space
  task automatic t_xdata;
    u_core_model.ireq(1'b0, AM_DIRECT, 3'h0, PAGE_SFR_ADDR, 8'h00);
    cmp_byte(irdata, PAGE_RESET);
    u_core_model.xreq(1'b1, 1'b0, EXTERNAL_DATA_RAM_HI, 8'hE1);
    u_core_model.xreq(1'b0, 1'b0, EXTERNAL_DATA_RAM_HI, 8'h00);
    cmp_byte(xrdata, 8'hE1);
    u_core_model.ireq(1'b1, AM_DIRECT, 3'h0, PAGE_SFR_ADDR, 8'h01);
    u_core_model.xreq(1'b0, 1'b1, 16'hAAFF, 8'h00);
    cmp_byte(xrdata, 8'hE1);
    u_core_model.xreq(1'b1, 1'b0, 16'h0203, 8'h55);
    u_core_model.xreq(1'b1, 1'b0, LED_HI, 8'h0F);
    cmp_byte(led_cache[31:24], 8'h55);
    @(posedge clk);
    #1;
    cmp_byte(led_cache[127:120], 8'h0F);
    u_core_model.xreq(1'b1, 1'b0, 16'h0210, 8'h66);
    u_core_model.xreq(1'b0, 1'b0, 16'h0210, 8'h00);
    cmp_bit(xrvalid, 1'b1);
    cmp_byte(xrdata, 8'h00);
  endtask

  // Region boundaries, then which operations each region allows
  task automatic t_flash;
    logic [15:0] fa[15] = '{16'h0000, 16'h3BFF, 16'h3C00, 16'h3FFF, 16'h4400, 16'h45FF, 16'h4600,
                            16'h47FF, 16'h4200, 16'h43FF, 16'h43A8, 16'h8000, 16'h81FF, 16'h4000, 16'h8200};
    logic [6:0]  fe[15] = '{7'h40, 7'h40, 7'h20, 7'h20, 7'h10, 7'h10, 7'h08, 7'h08, 7'h04, 7'h04,
                            7'h05, 7'h02, 7'h02, 7'h00, 7'h00};
    logic [15:0] oa[9] = '{16'h0000, 16'h3BFF, 16'h0100, 16'h3C00, 16'h4400, 16'h47FF, 16'h4200,
                           16'h8000, 16'h0000};
    flash_op_e   oo[9] = '{FOP_BLOCK, FOP_PAGE, FOP_WRITE, FOP_BLOCK, FOP_PAGE, FOP_WRITE, FOP_WRITE,
                           FOP_PAGE, FOP_WRITE};
    logic [8:0]  ok = 9'h037;
    for (int i = 0; i < 15; i++) begin
      u_core_model.freq(fa[i], FOP_NONE, 1'b0);
      cmp_sel(fsel, fe[i]);
    end
    for (int i = 0; i < 9; i++) begin
      u_core_model.freq(oa[i], oo[i], i != 8);
      cmp_bit(fop_ok, ok[i]);
      cmp_bit(fop_rej, !ok[i]);
    end
    for (int i = 0; i < 8; i++) begin
      u_core_model.uid_read(i);
      cmp_bit(fsel.unique_id_bytes, 1'b1);
    end
  endtask

  // Single place where the run ends
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Whole run is about 115 cycles; this span is far beyond it
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    checked = 0;
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    #1;
    cmp_bit(led_cache === '0, 1'b1);
    t_iram();
    t_refuse();
    t_xdata();
    t_flash();
    final_report();
  end
endmodule
